// ==== rtl/patpb_defs.svh ====
// Purpose: offsets, field positions and reset values of the register slice
// Assumes: byte addressed 12-bit configuration offsets
// Notes: definitions only
`ifndef PATPB_DEFS_SVH
`define PATPB_DEFS_SVH
`define PATPB_ADDR_W 12
`define PATPB_OFF_TBL1 12'h224
`define PATPB_OFF_TBL2 12'h228
`define PATPB_OFF_TBL3 12'h22C
`define PATPB_OFF_HDR 12'h280
`define PATPB_OFF_DSEL 12'h284
`define PATPB_OFF_DATA 12'h288
`define PATPB_RST_WORD 32'h0000_0000
`define PATPB_RST_SEL 8'h00
`define PATPB_SEL_MAX 8'h07
`define PATPB_PORT_MAX 4'h6
`define PATPB_CAPABILITY_IDENTIFIER_LSB 0
`define PATPB_CAPABILITY_IDENTIFIER_MSB 15
`define PATPB_CAPABILITY_VERSION_LSB 16
`define PATPB_CAPABILITY_VERSION_MSB 19
`define PATPB_NXT_LSB 20
`define PATPB_NXT_MSB 31
`define PATPB_SEL_MSB 7
`define PATPB_PHASE_W 4
`define PATPB_SLOTS 24
`define PATPB_FIRST_SLOT 8
`define PATPB_NVAL 8
`define PATPB_SEL_IDX_MSB 2
`define PATPB_WORD_W 32
`define PATPB_PER_WORD 8
`endif

// ==== rtl/patpb_pkg.sv ====
// Purpose: shared types of the register slice
// Assumes: patpb_defs.svh present
// Notes: types only
`include "patpb_defs.svh"
package patpb_pkg;
  // one register access from software
  typedef struct packed {
    logic [`PATPB_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } patpb_req_t;
  // power budgeting header fields
  typedef struct packed {
    logic [`PATPB_NXT_MSB-`PATPB_NXT_LSB:0] next_capability_pointer;
    logic [`PATPB_CAPABILITY_VERSION_MSB-`PATPB_CAPABILITY_VERSION_LSB:0] capability_version;
    logic [`PATPB_CAPABILITY_IDENTIFIER_MSB-`PATPB_CAPABILITY_IDENTIFIER_LSB:0] capability_identifier;
  } patpb_hdr_t;
endpackage

// ==== rtl/patpb_regs.sv ====
// Purpose: arbitration table words 1..3 and power budgeting header/select
// Assumes: synchronous reset, software port with read data one cycle later
// Notes: value registers live outside and are read through a select mux
//   header writes pass only while the unlock level is high
//   the select register keeps eight bits, the rest read zero
//   read data stand for one cycle, then fall back to zero
//   invalid phase entries are flagged for the arbiter to skip
//   the arbiter itself and table word 0 live elsewhere
//
// Overview of operation
// - phase fields hold granted port, reset zero
// - phases 8-31 in words 0x224 to 0x22C
// - capability identifier in low sixteen bits
// - capability version in bits 19:16
// - select field picks returned budget value
// - select above seven returns zero
// - arbiter skips invalid port entries without delay
// - identifiers 0-6 valid, 7-F reserved
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "patpb_defs.svh"
module patpb_regs (
  // clock and synchronous reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // software register port
  input wire logic [`PATPB_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  // header lock and stored budget values
  input wire logic hdr_unlock_in,
  input wire logic [`PATPB_NVAL*32-1:0] budget_values_in,
  output logic [31:0] rdata_out,
  // table view for the arbiter
  output logic [`PATPB_SLOTS*`PATPB_PHASE_W-1:0] slot_port_out,
  output logic [`PATPB_SLOTS-1:0] slot_valid_out,
  // header and select views
  output patpb_pkg::patpb_hdr_t cap_header_out,
  output logic [`PATPB_SEL_MSB:0] value_select_out
);
  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  // valid ingress identifier test
  function automatic logic port_ok(input logic [3:0] id);
    port_ok = (id <= `PATPB_PORT_MAX);
  endfunction

  // offset match of one mapped register
  function automatic logic offset_hit(
    input logic [`PATPB_ADDR_W-1:0] addr,
    input logic [`PATPB_ADDR_W-1:0] off
  );
    offset_hit = (addr == off);
  endfunction

  // one phase field out of a table word
  function automatic logic [`PATPB_PHASE_W-1:0] slot_field(
    input logic [31:0] word,
    input int unsigned idx
  );
    slot_field = word[idx*`PATPB_PHASE_W +: `PATPB_PHASE_W];
  endfunction

  // ------------------------------------------------------------
  // request carrier
  // ------------------------------------------------------------
  // software access bundled for the decoders
  patpb_pkg::patpb_req_t req;
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  // table words 1 to 3 and their next values
  logic [31:0] tbl [0:2];
  logic [31:0] next_tbl [0:2];
  // power budgeting header and its next value
  patpb_pkg::patpb_hdr_t hdr;
  patpb_pkg::patpb_hdr_t next_hdr;
  // value select and its next value
  logic [`PATPB_SEL_MSB:0] dsel;
  logic [`PATPB_SEL_MSB:0] next_dsel;
  // read data register and its next value
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  // offset hits, one per mapped register
  logic hit_tbl1;
  logic hit_tbl2;
  logic hit_tbl3;
  logic hit_hdr;
  logic hit_dsel;
  logic hit_data;
  logic hit_any;
  // write enables, one per writable register
  logic wen_tbl1;
  logic wen_tbl2;
  logic wen_tbl3;
  logic wen_hdr;
  logic wen_dsel;
  // read enables, one per readable register
  logic ren_tbl1;
  logic ren_tbl2;
  logic ren_tbl3;
  logic ren_hdr;
  logic ren_dsel;
  logic ren_data;

  assign hit_tbl1 = offset_hit(req.addr, `PATPB_OFF_TBL1);
  assign hit_tbl2 = offset_hit(req.addr, `PATPB_OFF_TBL2);
  assign hit_tbl3 = offset_hit(req.addr, `PATPB_OFF_TBL3);
  // header, select and readout offsets
  assign hit_hdr = offset_hit(req.addr, `PATPB_OFF_HDR);
  assign hit_dsel = offset_hit(req.addr, `PATPB_OFF_DSEL);
  assign hit_data = offset_hit(req.addr, `PATPB_OFF_DATA);
  // any mapped offset; unmapped reads fall back to zero
  assign hit_any = hit_tbl1 | hit_tbl2 | hit_tbl3 | hit_hdr | hit_dsel |
    hit_data;

  // write strobe qualified by the offset hit
  assign wen_tbl1 = req.wr & hit_tbl1;
  assign wen_tbl2 = req.wr & hit_tbl2;
  assign wen_tbl3 = req.wr & hit_tbl3;
  // header is locked unless the unlock level is high
  assign wen_hdr = req.wr & hit_hdr & hdr_unlock_in;
  assign wen_dsel = req.wr & hit_dsel;

  // read strobe qualified by the offset hit
  assign ren_tbl1 = req.rd & hit_tbl1;
  assign ren_tbl2 = req.rd & hit_tbl2;
  assign ren_tbl3 = req.rd & hit_tbl3;
  assign ren_hdr = req.rd & hit_hdr;
  assign ren_dsel = req.rd & hit_dsel;
  assign ren_data = req.rd & hit_data;

  // ------------------------------------------------------------
  // budget value selection
  // ------------------------------------------------------------
  logic sel_in_range;
  logic [`PATPB_SEL_IDX_MSB:0] sel_idx;
  logic [31:0] sel_value;
  assign sel_in_range = (dsel <= `PATPB_SEL_MAX);
  // index of the value within the budget bus
  assign sel_idx = dsel[`PATPB_SEL_IDX_MSB:0];
  // value picked by the low select bits
  assign sel_value =
    budget_values_in[sel_idx*`PATPB_WORD_W +: `PATPB_WORD_W];

  // ------------------------------------------------------------
  // arbitration table words
  // ------------------------------------------------------------
  // next table words
  always_comb begin
    next_tbl[0] = tbl[0];
    next_tbl[1] = tbl[1];
    next_tbl[2] = tbl[2];
    if (wen_tbl1) begin
      next_tbl[0] = req.wdata;
    end
    if (wen_tbl2) begin
      next_tbl[1] = req.wdata;
    end
    if (wen_tbl3) begin
      next_tbl[2] = req.wdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      tbl[0] <= `PATPB_RST_WORD;
      tbl[1] <= `PATPB_RST_WORD;
      tbl[2] <= `PATPB_RST_WORD;
    end else begin
      tbl[0] <= next_tbl[0];
      tbl[1] <= next_tbl[1];
      tbl[2] <= next_tbl[2];
    end
  end

  // ------------------------------------------------------------
  // power budgeting header
  // ------------------------------------------------------------
  // header fields by position
  always_comb begin
    next_hdr = hdr;
    if (wen_hdr) begin
      next_hdr.capability_identifier =
        req.wdata[`PATPB_CAPABILITY_IDENTIFIER_MSB:`PATPB_CAPABILITY_IDENTIFIER_LSB];
      next_hdr.capability_version =
        req.wdata[`PATPB_CAPABILITY_VERSION_MSB:`PATPB_CAPABILITY_VERSION_LSB];
      next_hdr.next_capability_pointer =
        req.wdata[`PATPB_NXT_MSB:`PATPB_NXT_LSB];
    end
  end

  // header register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      hdr <= `PATPB_RST_WORD;
    end else begin
      hdr <= next_hdr;
    end
  end

  // ------------------------------------------------------------
  // value select
  // ------------------------------------------------------------
  // select bits above the field dropped
  always_comb begin
    next_dsel = dsel;
    if (wen_dsel) begin
      next_dsel = req.wdata[`PATPB_SEL_MSB:0];
    end
  end

  // select register, zero after reset
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      dsel <= `PATPB_RST_SEL;
    end else begin
      dsel <= next_dsel;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // read data mux, zero when nothing is read
  always_comb begin
    next_rdata = `PATPB_RST_WORD;
    if (req.rd && !hit_any) begin
      next_rdata = `PATPB_RST_WORD;
    end
    if (ren_tbl1) begin
      next_rdata = tbl[0];
    end
    if (ren_tbl2) begin
      next_rdata = tbl[1];
    end
    if (ren_tbl3) begin
      next_rdata = tbl[2];
    end
    if (ren_hdr) begin
      next_rdata = hdr;
    end
    if (ren_dsel) begin
      next_rdata = 32'(dsel);
    end
    if (ren_data && sel_in_range) begin
      next_rdata = sel_value;
    end
  end

  // read data register, stands one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata <= `PATPB_RST_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // outputs to the arbiter
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PATPB_SLOTS; g = g + 1) begin : g_slot
      logic [31:0] word;
      logic [`PATPB_PHASE_W-1:0] field;
      // slot g is phase g + 8, eight phases to a word
      assign word = tbl[g / `PATPB_PER_WORD];
      // phase n at 4*(n mod 8)
      assign field = slot_field(word, g % `PATPB_PER_WORD);
      assign slot_port_out[g*`PATPB_PHASE_W +: `PATPB_PHASE_W] = field;
      assign slot_valid_out[g] = port_ok(field);
    end
  endgenerate

  // ------------------------------------------------------------
  // outputs to software
  // ------------------------------------------------------------
  // registered read data
  assign rdata_out = rdata;
  // header view for the capability walker
  assign cap_header_out = hdr;
  // select view for the value store
  assign value_select_out = dsel;
endmodule

// ==== test/patpb_regs_props.sv ====
// Purpose: checks for patpb_regs
// Assumes: sync high reset
// Notes: bound below
`timescale 1ns/10ps
module patpb_props (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [95:0] slot_port_out,
  input wire logic [23:0] slot_valid_out,
  input wire logic [7:0] value_select_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  idle_zero_a: assert property (
    !rd_in |=> rdata_out == 32'h0) else $error("idle");
  sel_high_a: assert property (
    rd_in && addr_in == 12'h288 && value_select_out > 8'h07
    |=> rdata_out == 32'h0) else $error("sel");
  table_hold_a: assert property (
    !wr_in |=> $stable(slot_port_out)) else $error("hold");
  word1_wr_a: assert property (
    wr_in && addr_in == 12'h224 |=> slot_port_out[31:0] == $past(wdata_in)
    ) else $error("word1");
  last_valid_a: assert property (
    slot_valid_out[23] == (slot_port_out[95:92] < 4'h7)) else $error("valid");
  sequence sel_write_s;
    wr_in && addr_in == 12'h284;
  endsequence
  sel_store_a: assert property (
    sel_write_s |=> value_select_out == $past(wdata_in[7:0])
    ) else $error("sel store");
endmodule
bind patpb_regs patpb_props props (.*);

// ==== test/tb_patpb_regs.sv ====
// Purpose: tests of patpb_regs
// Assumes: 1-cycle strobes
// Notes: verdict in end_of_test
`timescale 1ns/10ps
module tb_patpb_regs;
  logic sys_clk_in = 1'h0, reset_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
  logic hdr_unlock_in = 1'h0;
  logic [11:0] addr_in = 12'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [255:0] budget_values_in;
  logic [95:0] slot_port_out, tbl;
  logic [23:0] slot_valid_out;
  logic [7:0] value_select_out;
  patpb_pkg::patpb_hdr_t cap_header_out;
  int failures = 0, n_compared = 0;
  patpb_regs dut (.*);
  // 50 MHz clock
  always #10 sys_clk_in = ~sys_clk_in;
  task chk(input logic [95:0] s, e);
    n_compared++;
    if (s !== e) failures++;
    if (s !== e) $display("[ERR] %0t got %h exp %h", $time, s, e);
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge sys_clk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    #1 if (!w) chk(rdata_out, d);
    @(posedge sys_clk_in);
  endtask
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #40000 failures++;
    end_of_test;
  end
  // directed tests
  initial begin
    for (int k = 0; k < 8; k++) budget_values_in[32*k+:32] = ~32'(k);
    tbl = {32'h01234567, 32'hFEDCBA98, 32'h76543210};
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    for (int k = 0; k < 3; k++)
      acc(1'h1, 12'h224 + 12'(4 * k), tbl[32*k+:32]);
    chk(slot_port_out, tbl);
    chk(slot_valid_out, 24'hFE007F);
    acc(1'h1, 12'h280, 32'hABC10004);
    acc(1'h0, 12'h280, 32'h0);
    chk(cap_header_out, 32'h0);
    hdr_unlock_in <= 1'h1;
    acc(1'h1, 12'h280, 32'hABC10004);
    acc(1'h0, 12'h280, 32'hABC10004);
    chk(cap_header_out, 32'hABC10004);
    for (int k = 0; k < 10; k++) begin
      acc(1'h1, 12'h284, {24'hFFFFFF, 8'(k)});
      chk(value_select_out, 8'(k));
      acc(1'h0, 12'h288, k < 8 ? ~32'(k) : 32'h0);
    end
    acc(1'h0, 12'h220, 32'h0);
    end_of_test;
  end
endmodule
